// ### common/msc_pkg.sv
// Shared constants and types for the mute scene controller
package msc_pkg;
  localparam int MSC_NUM_CH       = 16;
  localparam int MSC_NUM_MANUAL   = 8;
  localparam int MSC_NUM_PATCH    = 128;
  localparam int MSC_PATCH_W      = 7;
  localparam int MSC_SRC_W        = 9;   // 8 manual + 1 sequence source
  localparam int MSC_SEQ_BIT      = 8;   // Sequence source bit in source vectors
  // Clock and hold timing
  localparam int MSC_CLK_HZ       = 10_000_000;
  localparam int MSC_PROMPT_MS    = 1000;
  localparam int MSC_CLEAR_MS     = 2000;
  localparam int MSC_PROMPT_CYC   = MSC_CLK_HZ / 1000 * MSC_PROMPT_MS;
  localparam int MSC_CLEAR_CYC    = MSC_CLK_HZ / 1000 * MSC_CLEAR_MS;
  localparam int MSC_HOLD_W       = 25;
  // MIDI
  localparam logic [7:0] MSC_MIDI_NOTE_OFF = 8'h80;
  localparam logic [7:0] MSC_MIDI_NOTE_ON  = 8'h90;
  localparam logic [7:0] MSC_MIDI_PGM      = 8'hc0;
  localparam logic [7:0] MSC_MIDI_SYX      = 8'hf0;
  localparam logic [7:0] MSC_MIDI_EOX      = 8'hf7;
  localparam logic [3:0] MSC_CHAN_RST      = 4'h0;  // Channel 01
  localparam logic [3:0] MSC_NIB_MASK      = 4'hf;
  localparam logic [6:0] MSC_DATA7_MASK    = 7'h7f;
  // Display codes
  typedef enum logic [3:0] {
    MSC_DSP_PATCH = 4'h0, MSC_DSP_CLRQ = 4'h1, MSC_DSP_CLEAR_DONE = 4'h2,
    MSC_DSP_CPYQ  = 4'h3, MSC_DSP_COPY = 4'h4, MSC_DSP_LOCK = 4'h5,
    MSC_DSP_EXT   = 4'h6, MSC_DSP_OFF  = 4'h7
  } msc_disp_e;
  // Status LED codes
  localparam logic [2:0] MSC_LED_OFF    = 3'h0;
  localparam logic [2:0] MSC_LED_RED    = 3'h1;
  localparam logic [2:0] MSC_LED_GREEN  = 3'h2;
  localparam logic [2:0] MSC_LED_BRED   = 3'h3;
  localparam logic [2:0] MSC_LED_BGREEN = 3'h4;
  // Register map
  localparam logic [7:0] MSC_REG_CFG    = 8'h00;
  localparam logic [7:0] MSC_REG_STAT   = 8'h04;
  localparam logic [7:0] MSC_REG_OUT    = 8'h08;
  localparam logic [7:0] MSC_REG_PATCH  = 8'h0c;
  localparam int MSC_CFG_ON     = 0;
  localparam int MSC_CFG_LOCK   = 1;
  localparam int MSC_CFG_EXT    = 2;
  localparam int MSC_CFG_PGM    = 3;
  localparam int MSC_CFG_BASE0  = 4;
  localparam int MSC_CFG_DUMP   = 5;
  localparam int MSC_CFG_CHAN   = 8;
  localparam logic [15:0] MSC_CFG_RST = 16'h0009;  // on, pgm, base 01, ch 01
  // Operating mode
  typedef enum logic [2:0] {
    MSC_M_NORM = 3'b001, MSC_M_EDIT = 3'b010, MSC_M_SAFE = 3'b100
  } msc_mode_e;
  // Transmit sequencer
  typedef enum logic [3:0] {
    MSC_T_IDLE = 4'b0001, MSC_T_PGM = 4'b0010, MSC_T_DUMP = 4'b0100,
    MSC_T_EOX = 4'b1000
  } msc_tx_e;
endpackage

// ### design/msc_top.sv
// Mute scene controller: scenes, safe scene, edit modes, MIDI messaging
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module msc_top
  import msc_pkg::*;
#(
  parameter int NUM_CH     = MSC_NUM_CH,
  parameter int PROMPT_CYC = MSC_PROMPT_CYC,
  parameter int CLEAR_CYC  = MSC_CLEAR_CYC
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 clk_en_i,
  // Panel buttons, debounced levels; presses are taken from their rising edges, holds from the levels
  input  wire logic                 up_i,
  input  wire logic                 down_i,
  input  wire logic                 advance_i,
  input  wire logic                 edit_btn_i,
  input  wire logic                 safe_btn_i,
  input  wire logic                 single_sw_i,
  input  wire logic                 seq_btn_i,
  input  wire logic [7:0]           manual_btn_i,
  input  wire logic [NUM_CH-1:0]    mute_sw_i,
  // MIDI byte streams
  input  wire logic                 midi_rx_valid_i,
  input  wire logic [7:0]           midi_rx_data_i,
  input  wire logic                 midi_tx_ready_i,
  output logic                      midi_tx_valid_o,
  output logic [7:0]                midi_tx_data_o,
  // Register port
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic [31:0]               reg_rdata_o,
  // Channel and panel outputs
  output logic [NUM_CH-1:0]         mute_o,
  output logic [3*NUM_CH-1:0]       status_led_o,
  output logic [6:0]                patch_disp_o,
  output logic                      pending_mark_o,
  output logic [3:0]                disp_code_o,
  output logic [MSC_SRC_W-1:0]      src_led_o,
  output logic [2:0]                mode_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage arrays and packed state

  logic [NUM_CH-1:0] patch_mem [MSC_NUM_PATCH];
  logic [NUM_CH-1:0] man_mem   [MSC_NUM_MANUAL];

  typedef struct packed {
    msc_mode_e                mode;
    logic [MSC_SRC_W-1:0]     active;     // Enabled sources
    logic [MSC_SRC_W-1:0]     edit_sel;   // One-hot source under edit
    logic [6:0]               patch;      // Active patch
    logic [6:0]               disp;       // Displayed patch
    logic [6:0]               saved;      // Patch held across edit
    logic [NUM_CH-1:0]        local_m;
    logic [NUM_CH-1:0]        safe_m;
    logic [NUM_CH-1:0]        ext_m;
    logic [15:0]              cfg;
    logic [MSC_HOLD_W-1:0]    hold;
    logic [3:0]               dcode;
    msc_tx_e                  tx;
    logic [7:0]               tx_byte;
    logic                     tx_vld;
    logic [7:0]               dump_idx;
    logic [3:0]               rx_stat;    // Running status kind
    logic                     rx_have1;
    logic [6:0]               rx_d1;
    logic [31:0]              rdata;
    logic [NUM_CH-1:0]        mute;
    logic [3*NUM_CH-1:0]      led;
    logic [MSC_SRC_W-1:0]     src_led;    // Registered source lamps
    logic                     pend;       // Registered pending marker
  } msc_state_s;

  msc_state_s q, d;

  // Input pins synchronised through two flops
  logic [NUM_CH+14:0] pin_s1_q, pin_s2_q;
  logic [NUM_CH+14:0] pins;
  assign pins = {mute_sw_i, manual_btn_i, seq_btn_i, single_sw_i, safe_btn_i,
                 edit_btn_i, advance_i, down_i, up_i};
  logic [NUM_CH+14:0] prev_q;

  logic up, dn, adv, edit_p, safe_p, seq_p, seq_h, single, edit_h, safe_h;
  logic [7:0] man_p;
  logic [NUM_CH-1:0] mute_p;
  logic [NUM_CH+14:0] rise;
  assign rise   = pin_s2_q & ~prev_q;
  assign up     = rise[0];
  assign dn     = rise[1];
  assign adv    = rise[2];
  assign edit_p = rise[3];
  assign edit_h = pin_s2_q[3];
  assign safe_p = rise[4];
  assign safe_h = pin_s2_q[4];
  assign single = pin_s2_q[5];
  assign seq_p  = rise[6];
  assign seq_h  = pin_s2_q[6];
  assign man_p  = rise[14:7];
  assign mute_p = rise[NUM_CH+14:15];

  // Scene pattern for a source vector, the OR of every enabled source
  function automatic logic [NUM_CH-1:0] scene_of(input logic [MSC_SRC_W-1:0] s,
                                                  input logic [6:0] p);
    logic [NUM_CH-1:0] r;
    r = '0;
    for (int i = 0; i < MSC_NUM_MANUAL; i++) begin
      if (s[i]) r = r | man_mem[i];
    end
    if (s[MSC_SEQ_BIT]) r = r | patch_mem[p];
    return r;
  endfunction

  // Maps a patch to its program number under the base setting
  function automatic logic [6:0] to_prog(input logic [6:0] p, input logic base0);
    return p;  // Patch index 0 is shown as 01 or 00; wire value is the same
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic              wr_patch, wr_man, copy_en;
  logic [6:0]        wr_patch_idx;
  logic [2:0]        wr_man_idx;
  logic [NUM_CH-1:0] wr_patch_val, wr_man_val;
  logic [NUM_CH-1:0] scene_m, edit_pat, member;
  logic              ctl_on, ext_on, pgm_on;
  logic [3:0]        chan;

  always_comb begin
    d            = q;
    wr_patch     = 1'b0;
    wr_man       = 1'b0;
    wr_patch_idx = q.disp;
    wr_man_idx   = '0;
    wr_patch_val = '0;
    wr_man_val   = '0;
    copy_en      = 1'b0;
    ctl_on       = q.cfg[MSC_CFG_ON];
    ext_on       = q.cfg[MSC_CFG_EXT];
    pgm_on       = q.cfg[MSC_CFG_PGM];
    chan         = q.cfg[MSC_CFG_CHAN +: 4];
    edit_pat     = scene_of(q.edit_sel, q.disp);
    d.tx_vld     = q.tx_vld & ~midi_tx_ready_i;
    d.rdata      = '0;

    // Local mute always toggles outside edit modes
    if (q.mode == MSC_M_NORM) d.local_m = q.local_m ^ mute_p;

    // Hold counter for clear and copy prompts
    if ((q.mode == MSC_M_EDIT && (safe_h || seq_h)) || (q.mode == MSC_M_SAFE && edit_h)) begin
      if (q.hold != '1) d.hold = q.hold + 1'b1;
    end else begin
      d.hold = '0;
    end

    unique case (q.mode)
      MSC_M_NORM: begin
        // Source enables, exclusive when single mode is on
        for (int i = 0; i < MSC_SRC_W; i++) begin
          if ((i < MSC_NUM_MANUAL ? man_p[i] : seq_p)) begin
            if (single) d.active = q.active[i] ? '0 : (MSC_SRC_W'(1) << i);
            else d.active[i] = ~q.active[i];
          end
        end
        if (up) d.disp = q.disp + 1'b1;
        if (dn) d.disp = q.disp - 1'b1;
        if (adv) begin
          // Browsed patch activates, else step by one
          d.patch = (q.disp != q.patch) ? q.disp : q.patch + 1'b1;
          d.disp  = d.patch;
        end
        if (edit_p && ctl_on && !ext_on) begin
          if (q.cfg[MSC_CFG_LOCK]) begin
            d.dcode = MSC_DSP_LOCK;
          end else begin
            d.mode  = MSC_M_EDIT;
            d.saved = q.patch;
            d.edit_sel = (single && q.active != '0) ? q.active
                                                    : (MSC_SRC_W'(1) << MSC_SEQ_BIT);
            d.dcode = MSC_DSP_PATCH;
          end
        end else if (safe_p && ctl_on && !ext_on) begin
          d.mode  = MSC_M_SAFE;
          d.dcode = MSC_DSP_PATCH;
        end
      end
      MSC_M_EDIT: begin
        if (seq_h && q.hold >= MSC_HOLD_W'(PROMPT_CYC)) d.dcode = MSC_DSP_CPYQ;
        // Copy: patch into manual only, with sequence under edit
        copy_en = seq_h && q.edit_sel[MSC_SEQ_BIT] && (man_p != '0);
        if (copy_en) begin
          for (int i = MSC_NUM_MANUAL - 1; i >= 0; i--) begin
            if (man_p[i]) wr_man_idx = 3'(i);
          end
          wr_man     = 1'b1;
          wr_man_val = patch_mem[q.disp];
          d.dcode    = MSC_DSP_COPY;
        end else if (!seq_h) begin
          for (int i = 0; i < MSC_NUM_MANUAL; i++) begin
            if (man_p[i]) d.edit_sel = MSC_SRC_W'(1) << i;
          end
        end
        // A press always comes with the held level, so it selects outside the hold test
        if (seq_p) d.edit_sel = MSC_SRC_W'(1) << MSC_SEQ_BIT;
        if (q.edit_sel[MSC_SEQ_BIT] && up) d.disp = q.disp + 1'b1;
        if (q.edit_sel[MSC_SEQ_BIT] && dn) d.disp = q.disp - 1'b1;
        // Membership toggles land in storage at once
        if (mute_p != '0) begin
          if (q.edit_sel[MSC_SEQ_BIT]) begin
            wr_patch = 1'b1;
            wr_patch_val = edit_pat ^ mute_p;
          end else begin
            wr_man = 1'b1;
            for (int i = 0; i < MSC_NUM_MANUAL; i++) begin
              if (q.edit_sel[i]) wr_man_idx = 3'(i);
            end
            wr_man_val = edit_pat ^ mute_p;
          end
        end
        if (safe_h && q.hold >= MSC_HOLD_W'(CLEAR_CYC)) begin
          d.dcode = MSC_DSP_CLEAR_DONE;
          if (q.hold == MSC_HOLD_W'(CLEAR_CYC)) begin
            if (q.edit_sel[MSC_SEQ_BIT]) wr_patch = 1'b1;
            else begin
              wr_man = 1'b1;
              for (int i = 0; i < MSC_NUM_MANUAL; i++) begin
                if (q.edit_sel[i]) wr_man_idx = 3'(i);
              end
            end
            wr_patch_val = '0;
            wr_man_val   = '0;
          end
        end else if (safe_h && q.hold >= MSC_HOLD_W'(PROMPT_CYC)) begin
          d.dcode = MSC_DSP_CLRQ;
        end
        if (edit_p) begin
          d.mode  = MSC_M_NORM;
          d.disp  = q.saved;
          d.patch = q.saved;
          d.dcode = MSC_DSP_PATCH;
        end
      end
      MSC_M_SAFE: begin
        d.safe_m = q.safe_m ^ mute_p;
        if (edit_h && q.hold >= MSC_HOLD_W'(CLEAR_CYC)) begin
          d.dcode  = MSC_DSP_CLEAR_DONE;
          d.safe_m = '0;
        end else if (edit_h && q.hold >= MSC_HOLD_W'(PROMPT_CYC)) begin
          d.dcode = MSC_DSP_CLRQ;
        end
        if (safe_p) begin
          d.mode  = MSC_M_NORM;
          d.dcode = MSC_DSP_PATCH;
        end
      end
      default: d.mode = MSC_M_NORM;
    endcase

    // Register writes: configuration, dump trigger
    if (reg_wr_i && reg_addr_i == MSC_REG_CFG) begin
      d.cfg = reg_wdata_i[15:0];
      d.cfg[MSC_CFG_DUMP] = 1'b0;
      if (reg_wdata_i[MSC_CFG_DUMP] && q.tx == MSC_T_IDLE) begin
        d.tx = MSC_T_DUMP;
        d.dump_idx = '0;
      end
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        MSC_REG_CFG:   d.rdata = {16'h0000, q.cfg};
        MSC_REG_STAT:  d.rdata = {16'h0000, 1'b0, q.mode, q.dcode, q.tx == MSC_T_IDLE,
                                  q.patch};
        MSC_REG_OUT:   d.rdata = 32'(q.mute);
        MSC_REG_PATCH: d.rdata = {16'h0000, 7'h00, q.active};
        default:       d.rdata = '0;
      endcase
    end

    // MIDI reception on the configured channel
    if (midi_rx_valid_i) begin
      if (midi_rx_data_i[7]) begin
        d.rx_have1 = 1'b0;
        d.rx_stat  = 4'h0;
        if (midi_rx_data_i[3:0] == chan) begin
          d.rx_stat = midi_rx_data_i[7:4];
        end
        if (midi_rx_data_i == MSC_MIDI_SYX) begin
          d.rx_stat  = MSC_MIDI_SYX[7:4];
          d.dump_idx = '0;
        end
      end else if (q.rx_stat == MSC_MIDI_PGM[7:4]) begin
        if (pgm_on && !ext_on) begin
          d.patch = midi_rx_data_i[6:0];
          d.disp  = midi_rx_data_i[6:0];
        end
      end else if (q.rx_stat == MSC_MIDI_SYX[7:4]) begin
        // Scene dump: pairs of seven-bit bytes per scene, patches then manuals
        d.rx_have1 = ~q.rx_have1;
        d.rx_d1    = midi_rx_data_i[6:0];
        if (q.rx_have1) begin
          d.dump_idx = q.dump_idx + 1'b1;
          if (q.dump_idx[7]) begin
            wr_man = q.dump_idx[6:3] == 4'h0;
            wr_man_idx = q.dump_idx[2:0];
            wr_man_val = NUM_CH'({midi_rx_data_i[1:0], q.rx_d1});
          end else begin
            wr_patch = 1'b1;
            wr_patch_idx = q.dump_idx[6:0];
            wr_patch_val = NUM_CH'({midi_rx_data_i[1:0], q.rx_d1});
          end
        end
      end else if (q.rx_stat == MSC_MIDI_NOTE_ON[7:4] ||
                   q.rx_stat == MSC_MIDI_NOTE_OFF[7:4]) begin
        d.rx_have1 = ~q.rx_have1;
        d.rx_d1    = midi_rx_data_i[6:0];
        if (q.rx_have1 && ext_on && q.rx_d1 < 7'(NUM_CH)) begin
          d.ext_m[q.rx_d1[3:0]] = (q.rx_stat == MSC_MIDI_NOTE_ON[7:4]) &&
                                  (midi_rx_data_i[6:0] != 7'h00);
        end
      end
    end

    // Program change out on recall
    if (pgm_on && q.mode == MSC_M_NORM && adv && q.tx == MSC_T_IDLE) d.tx = MSC_T_PGM;

    // Transmit sequencer
    if (!q.tx_vld || midi_tx_ready_i) begin
      unique case (q.tx)
        MSC_T_IDLE: ;
        MSC_T_PGM: begin
          d.tx_byte = {MSC_MIDI_PGM[7:4], chan};
          d.tx_vld  = 1'b1;
          d.tx      = MSC_T_EOX;
          d.dump_idx = '0;  // Marks the second byte as a program, not an end of dump
          d.rx_d1   = to_prog(d.patch, q.cfg[MSC_CFG_BASE0]);
        end
        MSC_T_DUMP: begin
          d.tx_byte = MSC_MIDI_SYX;
          d.tx_vld  = 1'b1;
          d.tx      = MSC_T_EOX;
          d.dump_idx = 8'h01;
        end
        MSC_T_EOX: begin
          d.tx_vld = 1'b1;
          d.tx_byte = MSC_MIDI_EOX;
          d.tx     = MSC_T_IDLE;
          if (q.dump_idx == '0) d.tx_byte = {1'b0, q.rx_d1};
        end
        default: d.tx = MSC_T_IDLE;
      endcase
    end

    // Mute and LED composition
    scene_m = ctl_on ? scene_of(q.active, q.patch) : '0;
    member  = edit_pat;
    for (int c = 0; c < NUM_CH; c++) begin
      if (ext_on && ctl_on) begin
        d.mute[c] = q.local_m[c] | q.ext_m[c];
      end else begin
        d.mute[c] = q.local_m[c] | (scene_m[c] & ~q.safe_m[c]);
      end
      d.led[3*c +: 3] = MSC_LED_OFF;
      if (ctl_on && !ext_on) begin
        if (q.mode == MSC_M_EDIT) begin
          if (member[c]) d.led[3*c +: 3] = MSC_LED_BRED;
        end else if (q.mode == MSC_M_SAFE) begin
          if (q.safe_m[c]) d.led[3*c +: 3] = MSC_LED_BGREEN;
        end else if (q.safe_m[c]) begin
          d.led[3*c +: 3] = MSC_LED_GREEN;
        end else if (scene_m[c]) begin
          d.led[3*c +: 3] = MSC_LED_RED;
        end
      end
    end
    d.src_led = (q.mode == MSC_M_EDIT) ? q.edit_sel : q.active;
    d.pend    = q.disp != q.patch;
    if (!ctl_on) d.dcode = MSC_DSP_OFF;
    else if (ext_on) d.dcode = MSC_DSP_EXT;
    else if (q.dcode == MSC_DSP_OFF || q.dcode == MSC_DSP_EXT) d.dcode = MSC_DSP_PATCH;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers and memories

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      q        <= '0;
      q.mode   <= MSC_M_NORM;
      q.tx     <= MSC_T_IDLE;
      q.cfg    <= MSC_CFG_RST;
      q.edit_sel <= MSC_SRC_W'(1) << MSC_SEQ_BIT;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      prev_q   <= '0;
    end else if (clk_en_i) begin
      q        <= d;
      pin_s1_q <= pins;
      pin_s2_q <= pin_s1_q;
      prev_q   <= pin_s2_q;
    end
  end

  // Scene memories; reset clears them, a loop is cheap at this depth
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < MSC_NUM_PATCH; i++) patch_mem[i] <= '0;
      for (int i = 0; i < MSC_NUM_MANUAL; i++) man_mem[i] <= '0;
    end else if (clk_en_i) begin
      if (wr_patch) patch_mem[wr_patch_idx] <= wr_patch_val;
      if (wr_man) man_mem[wr_man_idx] <= wr_man_val;
    end
  end

  assign mute_o          = q.mute;
  assign status_led_o    = q.led;
  assign patch_disp_o    = q.disp;
  assign pending_mark_o  = q.pend;
  assign disp_code_o     = q.dcode;
  assign src_led_o       = q.src_led;
  assign mode_o          = q.mode;
  assign midi_tx_valid_o = q.tx_vld;
  assign midi_tx_data_o  = q.tx_byte;
  assign reg_rdata_o     = q.rdata;

endmodule

// ### dv/msc_assertions.sv
// Port-level checker for the mute scene controller
`timescale 1ns/1ps
module msc_assertions
  import msc_pkg::*;
#(parameter int NUM_CH = MSC_NUM_CH) (
  input wire logic                sys_clk_i,
  input wire logic                sys_rst_i,
  input wire logic [7:0]          reg_addr_i,
  input wire logic                reg_rd_i,
  input wire logic [31:0]         reg_rdata_o,
  input wire logic                midi_tx_ready_i,
  input wire logic                midi_tx_valid_o,
  input wire logic [7:0]          midi_tx_data_o,
  input wire logic [NUM_CH-1:0]   mute_o,
  input wire logic [3*NUM_CH-1:0] status_led_o,
  input wire logic [3:0]          disp_code_o,
  input wire logic [2:0]          mode_o
);
  logic blink;
  // Any channel blinking; LEDs lag the mode by a cycle, so p_blink looks one back
  always_comb begin
    blink = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
      blink |= status_led_o[3*i+:3] inside {MSC_LED_BRED, MSC_LED_BGREEN};
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rst; $fell(sys_rst_i) |-> mute_o == '0 && mode_o == MSC_M_NORM; endproperty
  property p_rd0; !reg_rd_i |=> reg_rdata_o == '0; endproperty
  property p_unm; reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o == '0; endproperty
  property p_mode; $onehot(mode_o); endproperty
  property p_hold; midi_tx_valid_o && !midi_tx_ready_i |=>
    midi_tx_valid_o && $stable(midi_tx_data_o); endproperty
  property p_lock; disp_code_o == MSC_DSP_LOCK |-> mode_o == MSC_M_NORM; endproperty
  property p_clr; $rose(disp_code_o == MSC_DSP_CLEAR_DONE) |-> $past(disp_code_o) == MSC_DSP_CLRQ;
  endproperty
  property p_pgm; midi_tx_valid_o && midi_tx_ready_i && midi_tx_data_o[7:4] == 4'hc |=>
    ##[0:60] midi_tx_valid_o && !midi_tx_data_o[7]; endproperty
  property p_blink; mode_o == MSC_M_NORM && $past(mode_o) == MSC_M_NORM |-> !blink;
  endproperty
  a_rst: assert property(p_rst) else $error("bad state after reset");
  a_rd0: assert property(p_rd0) else $error("read data without read");
  a_unm: assert property(p_unm) else $error("unmapped read not zero");
  a_mode: assert property(p_mode) else $error("mode not one-hot");
  a_hold: assert property(p_hold) else $error("tx byte changed while stalled");
  a_lock: assert property(p_lock) else $error("edit entered while locked");
  a_clr: assert property(p_clr) else $error("clear without prompt");
  a_pgm: assert property(p_pgm) else $error("program byte missing");
  a_blink: assert property(p_blink) else $error("blink in normal mode");
  c_edit: cover property(mode_o == MSC_M_EDIT);
  c_safe: cover property(mode_o == MSC_M_SAFE);
  c_clr: cover property(disp_code_o == MSC_DSP_CLEAR_DONE);
endmodule
bind msc_top msc_assertions #(.NUM_CH(NUM_CH)) msc_assertions_inst (
  .sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .midi_tx_ready_i,
  .midi_tx_valid_o, .midi_tx_data_o, .mute_o, .status_led_o, .disp_code_o, .mode_o);

// ### dv/msc_midi_peer.sv
// Behavioural MIDI equipment on the far side of the controller
`timescale 1ns/1ps
module msc_midi_peer (
  input  wire logic       sys_clk_i,
  input  wire logic       slow_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o
);
  integer     seed = 32'h5711;
  logic [7:0] got[$];
  // Sink; when slow it stalls on random cycles to stress the hold
  always @(posedge sys_clk_i) begin
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    tx_ready_o <= slow_i ? ($random(seed) % 2 == 0) : 1'b1;
  end
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
  // One byte; the released line shows the inverse so stale data never looks valid
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b;
  endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the mute scene controller
`timescale 1ns/1ps
module tb;
  import msc_pkg::*;
  localparam int CC = 40;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [29:0] pins = '0;  // Buttons 0..5, manual 6..13, mute switches 14..29
  logic [7:0]  reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        slow = 1'b0;
  logic        single = 1'b0;
  logic        midi_tx_ready_i, midi_rx_valid_i, midi_tx_valid_o, pend;
  logic [7:0]  midi_rx_data_i, midi_tx_data_o;
  logic [31:0] reg_rdata_o, v;
  logic [15:0] mute_o;
  logic [47:0] status_led_o;
  logic [6:0]  patch_disp_o;
  logic [3:0]  disp_code_o, dsp;
  logic [8:0]  src_led_o;
  logic [2:0]  mode_o;
  integer      seed = 32'h5711;
  int          fails = 0, checks_done = 0, ch, lm = 0, sc = 0, sf = 0, seq_on = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  msc_top #(.PROMPT_CYC(20), .CLEAR_CYC(CC)) msc_top_inst (
    .sys_clk_i, .sys_rst_i, .clk_en_i(1'b1), .up_i(pins[0]), .down_i(pins[1]),
    .advance_i(pins[2]), .edit_btn_i(pins[3]), .safe_btn_i(pins[4]), .single_sw_i(single),
    .seq_btn_i(pins[5]), .manual_btn_i(pins[13:6]), .mute_sw_i(pins[29:14]),
    .midi_rx_valid_i, .midi_rx_data_i, .midi_tx_ready_i, .midi_tx_valid_o, .midi_tx_data_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mute_o, .status_led_o,
    .patch_disp_o, .pending_mark_o(pend), .disp_code_o, .src_led_o, .mode_o);
  msc_midi_peer peer_inst (.sys_clk_i, .slow_i(slow), .tx_valid_i(midi_tx_valid_o),
    .tx_data_i(midi_tx_data_o), .tx_ready_o(midi_tx_ready_i), .rx_valid_o(midi_rx_valid_i),
    .rx_data_o(midi_rx_data_i));
  ////////////////////////////////////////////////////////////////////////////////
  // Model: scene pattern only mutes while its source is on and the channel is not safe
  function automatic logic [15:0] exp_mute();
    return 16'(lm | (seq_on != 0 ? sc & ~sf : 0));
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Hold a pin n edges; the display is caught before release since it may revert
  task automatic hold(input int i, input int n);
    @(posedge sys_clk_i);
    pins[i] <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    #1 dsp = disp_code_o;
    pins[i] <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
  endtask
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ch = {$random(seed)} % 16;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    bus(MSC_REG_CFG, 32'h0, 1'b0);
    chk(v, {16'h0, MSC_CFG_RST});
    bus(8'h40, 32'h0, 1'b0);
    chk(v, 32'h0);
    hold(14 + ch, 3);
    lm = 1 << ch;
    chk(mute_o, exp_mute());
    hold(14 + ch, 3);
    lm = 0;
    hold(3, 3);
    chk(mode_o, MSC_M_EDIT);
    hold(14 + ch, 3);
    sc = 1 << ch;
    chk(status_led_o[3*ch+:3], MSC_LED_BRED);
    hold(3, 3);
    hold(5, 3);
    seq_on = 1;
    chk(mute_o, exp_mute());
    hold(4, 3);
    hold(14 + ch, 3);
    sf = 1 << ch;
    chk(mute_o, exp_mute());
    chk(status_led_o[3*ch+:3], MSC_LED_BGREEN);
    hold(4, 3);
    chk(status_led_o[3*ch+:3], MSC_LED_GREEN);
    chk(mute_o, exp_mute());
    // Empty the safe scene, then the patch under edit, each by a long hold
    hold(4, 3);
    hold(3, CC + 5);
    chk(dsp, MSC_DSP_CLEAR_DONE);
    sf = 0;
    hold(4, 3);
    chk(mute_o, exp_mute());
    hold(3, 3);
    hold(4, CC + 5);
    chk(dsp, MSC_DSP_CLEAR_DONE);
    sc = 0;
    chk(mute_o, exp_mute());
    hold(3, 3);
    // Advance with a stalling sink, then recall from a received program change
    slow = 1'b1;
    hold(2, 3);
    for (int k = 0; k < 200 && peer_inst.got.size() < 2; k++) @(posedge sys_clk_i);
    chk(peer_inst.got[0], {MSC_MIDI_PGM[7:4], MSC_CHAN_RST});
    chk(peer_inst.got[1], 8'h01);
    chk(patch_disp_o, 7'h01);
    peer_inst.send(MSC_MIDI_PGM);
    peer_inst.send(8'h05);
    for (int k = 0; k < 50 && patch_disp_o !== 7'h05; k++) @(posedge sys_clk_i);
    chk(patch_disp_o, 7'h05);
    chk(pend, 1'b0);
    hold(0, 3);
    chk(pend, 1'b1);
    // Single mode: a manual press replaces the sequence source
    single <= 1'b1;
    hold(6, 3);
    chk(src_led_o, 9'h001);
    bus(MSC_REG_CFG, 32'h000b, 1'b1);
    hold(3, 3);
    chk(dsp, MSC_DSP_LOCK);
    chk(mode_o, MSC_M_NORM);
    give_verdict();
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #2_000_000;
    fails++;
    give_verdict();
  end
endmodule
